// [hdl/status_flags.v]
// status flag register of the core and its update logic
// assumes the datapath presents one instruction per cycle on EX_VALID with
// its operands; flags commit at the same edge as the instruction result
//
// Function
// RL1: the xor flag takes overflow xor the top bit of the current result.
// RL2: plain subtract loads the chained zero flag with the zero flag.
// RL3: subtract with borrow loads chained zero with its old value and the zero result.
// RL4: every other instruction leaves the chained zero flag alone.
// RL5: watchdog expiry sets the watchdog time-out flag.
// RL6: power-up, watchdog clear or halt clears the watchdog time-out flag.
// RL7: power-up or watchdog clear clears the power-down flag.
// RL8: halt sets the power-down flag.
// RL9: overflow is carry into the top bit differing from carry out of it.
// RL10: zero is set on an all-zero arithmetic or logic result, cleared otherwise.
// RL11: half carry is the carry out of the low nibble, or no nibble borrow on subtract.
// RL12: carry is the add carry or the absence of borrow on subtract.
// RL13: rotate through carry shifts carry in and captures the bit shifted out.
// RL14: software writes never change the time-out or power-down flags.
// RL15: all flag updates of an instruction land on the edge that commits it.
`timescale 1ns/10ps
`default_nettype none
`include "flag_consts.vh"
module status_flags
(
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        EX_VALID,
  input  wire [3:0]  EX_OP,
  input  wire [7:0]  EX_A,
  input  wire [7:0]  EX_B,
  input  wire        EX_WDT_CLEAR,
  input  wire        EX_HALT,
  input  wire        WDT_EXPIRE,
  output reg  [7:0]  EX_RESULT,
  output reg  [7:0]  FLAGS
);

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  // sum with carries: returns {c_out, c_into7, c_nib, result}
  function [10:0] add8;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [7:0] lo7;
    reg   [8:0] full;
    begin
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      lo7  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      add8 = {full[8], lo7[7], lo[4], full[7:0]};
    end
  endfunction

  // subtract as a plus inverted b; carry in high means no borrow pending
  function [10:0] sub8;
    input [7:0] a;
    input [7:0] b;
    input       nb;
    begin
      sub8 = add8(a, ~b, nb);
    end
  endfunction

  // all-zero test of an 8-bit result
  function zero8;
    input [7:0] v;
    begin
      zero8 = (v == 8'h00);
    end
  endfunction

  reg  [7:0]  flags_reg;
  reg  [7:0]  flags_next;
  reg  [7:0]  res_next;
  reg  [10:0] sum;
  reg         arith;
  reg         wdto_cur;
  reg         pdown_cur;
  reg         sw_hit;
  reg         wdt_sync1_reg;
  reg         wdt_sync2_reg;
  reg         wdt_prev_reg;
  wire        wdt_rise;
  wire        sel_flags;
  wire        sel_ctrl;
  wire        op_rotate;
  wire        op_sets_zero;
  wire        op_sub_plain;
  wire        op_sub_borrow;
  wire        sys_clear;
  wire        sys_halt;
  reg  [31:0] prdata_next;
  reg         pready_next;
  reg         pslverr_next;

  // ---------------------------------------------------------------
  // watchdog expiry synchroniser
  // ---------------------------------------------------------------
  // watchdog expiry arrives from another domain
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      wdt_sync1_reg <= 1'b0;
      wdt_sync2_reg <= 1'b0;
      wdt_prev_reg  <= 1'b0;
    end
    else
    begin
      wdt_sync1_reg <= WDT_EXPIRE;
      wdt_sync2_reg <= wdt_sync1_reg;
      wdt_prev_reg  <= wdt_sync2_reg;
    end
  end
  assign wdt_rise = wdt_sync2_reg & ~wdt_prev_reg;

  assign sel_flags = (PADDR == `FLG_OFFSET);
  assign sel_ctrl  = (PADDR == `FLG_CTRL_OFFSET);

  // ---------------------------------------------------------------
  // operation classes
  // ---------------------------------------------------------------
  assign op_rotate     = (EX_OP == `OP_RLC) | (EX_OP == `OP_RRC);
  assign op_sets_zero  = (EX_OP != `OP_NONE) & ~op_rotate;
  assign op_sub_plain  = (EX_OP == `OP_SUB);
  assign op_sub_borrow = (EX_OP == `OP_SBC);
  assign sys_clear     = EX_VALID & EX_WDT_CLEAR;
  assign sys_halt      = EX_VALID & EX_HALT;

  // ---------------------------------------------------------------
  // next flag value
  // ---------------------------------------------------------------
  always @*
  begin
    flags_next = flags_reg;
    res_next   = EX_RESULT;
    sum        = 11'h000;
    arith      = 1'b0;
    sw_hit     = PSEL & PENABLE & PWRITE & PSTRB[0] & sel_flags;
    // software write lands first; an instruction in the same cycle overrides the flags it updates
    if (sw_hit)
    begin
      flags_next = (flags_reg & ~`FLG_SW_MASK) | (PWDATA[7:0] & `FLG_SW_MASK); // RL14
    end
    if (EX_VALID)
    begin
      // one shared adder; subtracts add the inverted operand
      case (EX_OP)
        `OP_ADD:
        begin
          sum   = add8(EX_A, EX_B, 1'b0);
          arith = 1'b1;
        end
        `OP_ADC:
        begin
          sum   = add8(EX_A, EX_B, flags_reg[`FLG_BIT_CARRY]);
          arith = 1'b1;
        end
        `OP_SUB:
        begin
          sum   = sub8(EX_A, EX_B, 1'b1);
          arith = 1'b1;
        end
        `OP_SBC:
        begin
          sum   = sub8(EX_A, EX_B, flags_reg[`FLG_BIT_CARRY]);
          arith = 1'b1;
        end
        `OP_INCDEC:
        begin
          sum = add8(EX_A, EX_B, 1'b0);
        end
        `OP_LOGIC:
        begin
          sum = {3'b000, EX_A & EX_B};
        end
        `OP_RLC:
        begin
          sum = {EX_A[7], 2'b00, EX_A[6:0], flags_reg[`FLG_BIT_CARRY]};
        end
        `OP_RRC:
        begin
          sum = {EX_A[0], 2'b00, flags_reg[`FLG_BIT_CARRY], EX_A[7:1]};
        end
        default:
        begin
          sum = {3'b000, EX_A};
        end
      endcase
      res_next = sum[7:0];
      if (op_sets_zero)
      begin
        flags_next[`FLG_BIT_ZERO] = zero8(sum[7:0]); // RL10
      end
      if (arith)
      begin
        flags_next[`FLG_BIT_CARRY] = sum[10]; // RL12
        flags_next[`FLG_BIT_HALF]  = sum[8]; // RL11
        flags_next[`FLG_BIT_OVF]   = sum[10] ^ sum[9]; // RL9
        flags_next[`FLG_BIT_XOVF]  = (sum[10] ^ sum[9]) ^ sum[7]; // RL1
      end
      if (op_rotate)
      begin
        flags_next[`FLG_BIT_CARRY] = sum[10]; // RL13
      end
      if (op_sub_plain)
      begin
        flags_next[`FLG_BIT_CHZERO] = zero8(sum[7:0]); // RL2
      end
      else if (op_sub_borrow)
      begin
        flags_next[`FLG_BIT_CHZERO] = flags_reg[`FLG_BIT_CHZERO] & zero8(sum[7:0]); // RL3
      end
      // other ops keep chained zero as flags_next holds it: flags_reg, or a software write in the same cycle
      // RL4
    end
    // system flags: expiry wins over a clear in the same cycle
    wdto_cur  = flags_reg[`FLG_BIT_WDTO];
    pdown_cur = flags_reg[`FLG_BIT_PDOWN];
    if (sys_clear || sys_halt)
    begin
      wdto_cur = 1'b0; // RL6
    end
    if (wdt_rise)
    begin
      wdto_cur = 1'b1; // RL5
    end
    if (sys_clear)
    begin
      pdown_cur = 1'b0; // RL7
    end
    else if (sys_halt)
    begin
      pdown_cur = 1'b1; // RL8
    end
    flags_next[`FLG_BIT_WDTO]  = wdto_cur;
    flags_next[`FLG_BIT_PDOWN] = pdown_cur;
  end

  // ---------------------------------------------------------------
  // flag and result registers
  // ---------------------------------------------------------------
  // FLAGS mirrors flags_reg so the port comes straight from a flip-flop
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      flags_reg <= `FLG_RESET; // RL6 RL7
      FLAGS     <= `FLG_RESET;
    end
    else
    begin
      flags_reg <= flags_next; // RL15
      FLAGS     <= flags_next;
    end
  end

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      EX_RESULT <= 8'h00;
    end
    else
    begin
      EX_RESULT <= res_next; // RL15
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // ready follows the setup cycle by one edge, so every access is wait-free
  always @*
  begin
    pready_next  = PSEL & ~PENABLE;
    pslverr_next = PSEL & ~PENABLE & ~(sel_flags | sel_ctrl);
    prdata_next  = 32'h00000000;
    if (PSEL && !PENABLE && !PWRITE && sel_flags)
    begin
      prdata_next = {24'h000000, flags_reg};
    end
  end

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PRDATA  <= prdata_next;
      PREADY  <= pready_next;
      PSLVERR <= pslverr_next;
    end
  end

endmodule
`default_nettype wire

// [shared/flag_consts.vh]
// flag register constants: bit positions, register offset, reset values
// assumes a 32-bit APB slave with one aligned word per register
`ifndef FLAG_CONSTS_VH
`define FLAG_CONSTS_VH
`define FLG_BIT_CARRY      3'd0
`define FLG_BIT_HALF       3'd1
`define FLG_BIT_ZERO       3'd2
`define FLG_BIT_OVF        3'd3
`define FLG_BIT_PDOWN      3'd4
`define FLG_BIT_WDTO       3'd5
`define FLG_BIT_CHZERO     3'd6
`define FLG_BIT_XOVF       3'd7
`define FLG_OFFSET         12'h000
`define FLG_CTRL_OFFSET    12'h004
`define FLG_RESET          8'h00
`define FLG_SW_MASK        8'hCF
`define OP_NONE            4'h0
`define OP_ADD             4'h1
`define OP_ADC             4'h2
`define OP_SUB             4'h3
`define OP_SBC             4'h4
`define OP_LOGIC           4'h5
`define OP_RLC             4'h6
`define OP_RRC             4'h7
`define OP_INCDEC          4'h8
`endif

// [dv/flags_sva.sv]
// assertions on the status flag block ports
// assumes a bind onto status_flags
`timescale 1ns/10ps
`default_nettype none
`include "flag_consts.vh"
module flags_sva
(
  input wire       SYS_CLK,
  input wire       RST,
  input wire       PSEL,
  input wire       PENABLE,
  input wire       PWRITE,
  input wire       PREADY,
  input wire       EX_VALID,
  input wire [3:0] EX_OP,
  input wire [7:0] EX_A,
  input wire       EX_HALT,
  input wire       EX_WDT_CLEAR,
  input wire       WDT_EXPIRE,
  input wire [7:0] EX_RESULT,
  input wire [7:0] FLAGS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence sw_wr_s; PSEL && PENABLE && PWRITE && !EX_VALID; endsequence
  a_apb_ready: assert property (setup_s |=> PREADY) else $error("no ready after setup");
  a_sw_pdown: assert property (sw_wr_s |=> $stable(FLAGS[4]))
    else $error("write moved power-down flag");
  a_zero_add: assert property (EX_VALID && EX_OP == `OP_ADD |=>
    FLAGS[2] == (EX_RESULT == 8'h00)) else $error("zero flag wrong");
  a_xor_msb: assert property (EX_VALID && EX_OP == `OP_SUB |=>
    FLAGS[7] == (FLAGS[3] ^ EX_RESULT[7])) else $error("xor flag wrong");
  a_sub_chain: assert property (EX_VALID && EX_OP == `OP_SUB |=>
    FLAGS[6] == FLAGS[2]) else $error("chained zero wrong");
  a_halt_pdown: assert property (EX_VALID && EX_HALT && !EX_WDT_CLEAR |=>
    FLAGS[4]) else $error("halt left power-down clear");
  a_clr_pdown: assert property (EX_VALID && EX_WDT_CLEAR |=> !FLAGS[4])
    else $error("clear left power-down set");
  a_wdt_set: assert property ($rose(WDT_EXPIRE) |-> ##[1:4] FLAGS[5])
    else $error("expiry not flagged");
  a_rot_carry: assert property (EX_VALID && EX_OP == `OP_RLC |=>
    FLAGS[0] == $past(EX_A[7])) else $error("rotate carry wrong");
endmodule
`default_nettype wire

// [dv/exec_model.sv]
// execution datapath model: issues one instruction per call
// assumes the flag block samples every edge with valid high
`timescale 1ns/10ps
`default_nettype none
module exec_model
(
  input  wire logic       clk,
  output var  logic       ev,
  output var  logic [3:0] op,
  output var  logic [7:0] a,
  output var  logic [7:0] b,
  output var  logic       clr,
  output var  logic       hlt
);
  initial {ev, op, a, b, clr, hlt} = '0;
  task automatic issue(input logic [3:0] o, input logic [7:0] x, y, input logic c, h);
    @(posedge clk);
    {ev, op, a, b, clr, hlt} <= {1'b1, o, x, y, c, h};
    @(posedge clk);
    {ev, a, b, clr, hlt} <= {1'b0, ~x, ~y, 2'b00};
  endtask
endmodule
`default_nettype wire

// [dv/test_cpu_status_flag_logic.sv]
// self-checking bench for the status flag block
// assumes the exec_model partner and the flags_sva checker
`timescale 1ns/10ps
`default_nettype none
`include "flag_consts.vh"
module test_cpu_status_flag_logic;
  logic clk, rst, psel, pen, pw, wdt, prdy, perr, ev, clr, hlt;
  logic [11:0] pa;
  logic [31:0] pwd, prd;
  logic [3:0]  op;
  logic [7:0]  a, b, res, flg, x;
  logic [8:0]  q[$];
  int          n_fail, checks, seed;
  exec_model dp (.clk(clk), .ev(ev), .op(op), .a(a), .b(b), .clr(clr), .hlt(hlt));
  status_flags uut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pw),
    .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .EX_VALID(ev), .EX_OP(op), .EX_A(a), .EX_B(b), .EX_WDT_CLEAR(clr), .EX_HALT(hlt),
    .WDT_EXPIRE(wdt), .EX_RESULT(res), .FLAGS(flg));
  task summarize;
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string name, input logic [8:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // result and flag ports one edge after the commit edge
  task automatic exec_chk(input logic [7:0] r, input logic [7:0] f);
    @(posedge clk);
    check("result", {1'b0, res}, {1'b0, r});
    check("flags", {1'b0, flg}, {1'b0, f});
  endtask
  // a read notes {error, flags} as expected; a write sends e[7:0]
  task automatic apb(input logic w, input logic [11:0] ad, input logic [8:0] e);
    int i;
    if (!w) q.push_back(e);
    @(posedge clk);
    {psel, pen, pw, pa, pwd} <= {2'b10, w, ad, 24'h0, e[7:0]};
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20 && prdy !== 1'b1; i++) @(posedge clk);
    if (i < 20) {psel, pen} <= 2'b00;
    else
    begin
      n_fail++;
      summarize;
    end
  endtask
  always @(posedge clk)
    if (prdy === 1'b1 && pw === 1'b0) check("read", {perr, prd[7:0] & {8{!perr}}}, q.pop_front());
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rst, psel, pen, pw, pa, pwd, wdt} = {1'b1, 48'h0};
    {n_fail, checks, seed} = {32'd0, 32'd0, 32'd36};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, `FLG_OFFSET, 9'h000);
    apb(0, `FLG_CTRL_OFFSET, 9'h000);
    apb(0, 12'h008, 9'h100);
    x = 8'($random(seed));
    dp.issue(`OP_SUB, x, x, 0, 0);
    exec_chk(8'h00, 8'h47);
    apb(0, `FLG_OFFSET, 9'h047);
    x = 8'($random(seed)) | 8'h01;
    dp.issue(`OP_SBC, x, 8'h00, 0, 0);
    exec_chk(x, {x[7], 7'h03});
    apb(0, `FLG_OFFSET, {1'b0, x[7], 7'h03});
    dp.issue(`OP_NONE, x, x, 0, 1);
    apb(0, `FLG_OFFSET, {1'b0, x[7], 7'h13});
    apb(1, `FLG_OFFSET, 9'h000);
    apb(0, `FLG_OFFSET, 9'h010);
    dp.issue(`OP_NONE, x, x, 1, 0);
    apb(0, `FLG_OFFSET, 9'h000);
    wdt <= 1'b1;
    repeat (6) @(posedge clk);
    wdt <= 1'b0;
    apb(0, `FLG_OFFSET, 9'h020);
    apb(1, `FLG_OFFSET, 9'h0FF);
    apb(0, `FLG_OFFSET, 9'h0EF);
    dp.issue(`OP_NONE, x, x, 0, 1);
    apb(0, `FLG_OFFSET, 9'h0DF);
    dp.issue(`OP_RLC, x, x, 0, 0);
    exec_chk({x[6:0], 1'b1}, {7'h6F, x[7]});
    dp.issue(`OP_ADD, 8'h80, 8'h80, 0, 0);
    exec_chk(8'h00, 8'hDD);
    apb(0, `FLG_OFFSET, 9'h0DD);
    summarize;
  end
endmodule
bind status_flags flags_sva chk (.*);
`default_nettype wire
